// file: core/loader_pkg.sv
// shared constants, modes and carriers of the serial loader checksum and password block
// assumes a 20-bit byte address space for flash and ram, and one byte per received stream beat
package loader_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [19:0] FLASH_LO = 20'h04000;
	localparam logic [19:0] FLASH_HI = 20'h21EFF;
	localparam logic [19:0] TOP_LO = 20'hFFF00;
	localparam logic [19:0] TOP_HI = 20'hFFFFF;
	localparam logic [19:0] BLANK_LO = 20'hFFFE0;
	localparam logic [20:0] PW_CMP_LIMIT = 21'h21F00;

	// ----------------------------------------------------------------
	// record, password and output sum window constants
	// ----------------------------------------------------------------
	localparam logic [7:0] START_MARK = 8'h3A;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] REC_DATA = 8'h00;
	localparam logic [7:0] REC_END = 8'h01;
	localparam logic [7:0] REC_EXT = 8'h02;
	localparam logic [7:0] EXT_LEN = 8'h02;
	localparam logic [7:0] END_LEN = 8'h00;
	localparam logic [15:0] EXT_LIMIT = 16'h1000;
	localparam logic [7:0] PW_MIN_COUNT = 8'h08;
	localparam logic [1:0] PW_RUN_LIMIT = 2'h2;
	localparam logic [2:0] PW_ADDR_BYTES = 3'h6;
	localparam logic [7:0] ID_SUM_FIRST = 8'h09;
	localparam logic [7:0] ID_SUM_LAST = 8'h12;
	localparam logic [7:0] STATUS_SUM_FIRST = 8'h09;
	localparam logic [7:0] STATUS_SUM_LAST = 8'h0C;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_FLASH_WRITE,
		MODE_RAM_LOAD,
		MODE_SUM_OUT,
		MODE_ID_OUT,
		MODE_STATUS_OUT,
		MODE_ERASE
	} mode_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_type;

	typedef struct packed {
		logic valid;
		logic [19:0] addr;
		logic [7:0] data;
	} write_type;

	typedef struct packed {
		logic rd;
		logic ram;
		logic [19:0] addr;
	} mem_req_type;

endpackage

// file: core/checksum_acc.sv
// 16-bit byte-wise checksum accumulator
// assumes clear and add never assert in the same cycle; clear wins if they do
`timescale 1ns/1ps
`default_nettype none

module checksum_acc
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic add_i,
	input wire logic [7:0] byte_i,
	output logic [15:0] sum_o
);

	logic [15:0] sum_reg;
	logic [15:0] sum_next;

	// carries past bit 15 fall away on purpose
	assign sum_next = clear_i ? 16'h0000 : (add_i ? sum_reg + {8'h00, byte_i} : sum_reg);
	assign sum_o = sum_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sum_reg <= 16'h0000;
		else
			sum_reg <= sum_next;
	end

endmodule

`default_nettype wire

// file: core/hex_record_check.sv
// binary hex record parser: checks format, yields payload bytes with their address
// assumes the caller clears it at the start of each operation and feeds bytes only while records are due
`timescale 1ns/1ps
`default_nettype none

module hex_record_check
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire loader_pkg::byte_type rx_i,
	output loader_pkg::write_type pay_o,
	output logic end_o,
	output logic err_o
);

	typedef enum {R_MARK, R_LEN, R_ADR_HI, R_ADR_LO, R_TYPE, R_DATA, R_SUM} rec_state_type;

	rec_state_type state_reg, state_next;
	logic [7:0] len_reg, len_next;
	logic [7:0] type_reg, type_next;
	logic [15:0] off_reg, off_next;
	logic [15:0] ext_reg, ext_next;
	logic [7:0] sum_reg, sum_next;
	logic [7:0] idx_reg, idx_next;
	loader_pkg::write_type pay_reg, pay_next;
	logic end_reg, end_next;
	logic err_reg, err_next;

	wire logic [7:0] sum_after = sum_reg + rx_i.data;
	wire logic [19:0] pay_addr = 20'({ext_reg, 4'h0}) + {4'h0, off_reg};
	wire logic type_bad = rx_i.data != loader_pkg::REC_DATA && rx_i.data != loader_pkg::REC_END
		&& rx_i.data != loader_pkg::REC_EXT;
	wire logic ext_len_bad = rx_i.data == loader_pkg::REC_EXT && len_reg != loader_pkg::EXT_LEN;
	wire logic end_len_bad = rx_i.data == loader_pkg::REC_END && len_reg != loader_pkg::END_LEN;
	wire logic ext_high = rx_i.data == loader_pkg::REC_DATA && ext_reg >= loader_pkg::EXT_LIMIT;

	always_comb
	begin
		state_next = state_reg;
		len_next = len_reg;
		type_next = type_reg;
		off_next = off_reg;
		ext_next = ext_reg;
		sum_next = sum_reg;
		idx_next = idx_reg;
		pay_next = '0;
		end_next = 1'b0;
		err_next = 1'b0;
		if (clear_i)
		begin
			state_next = R_MARK;
			ext_next = 16'h0000;
		end
		else if (rx_i.valid)
		begin
			sum_next = sum_after;
			unique case (state_reg)
				R_MARK:
				begin
					// anything but the start mark is dropped between records
					sum_next = 8'h00;
					if (rx_i.data == loader_pkg::START_MARK)
						state_next = R_LEN;
				end
				R_LEN:
				begin
					len_next = rx_i.data;
					state_next = R_ADR_HI;
				end
				R_ADR_HI:
				begin
					off_next = {rx_i.data, off_reg[7:0]};
					state_next = R_ADR_LO;
				end
				R_ADR_LO:
				begin
					off_next = {off_reg[15:8], rx_i.data};
					state_next = R_TYPE;
				end
				R_TYPE:
				begin
					type_next = rx_i.data;
					idx_next = 8'h00;
					if (type_bad || ext_len_bad || end_len_bad || ext_high)
						err_next = 1'b1;
					state_next = (len_reg == 8'h00) ? R_SUM : R_DATA;
				end
				R_DATA:
				begin
					idx_next = idx_reg + 8'h01;
					if (type_reg == loader_pkg::REC_EXT)
						ext_next = {ext_reg[7:0], rx_i.data};
					else
					begin
						// only payload is passed on; framing bytes never reach the write port
						pay_next = '{valid: 1'b1, addr: pay_addr, data: rx_i.data};
						off_next = off_reg + 16'h0001;
					end
					if (idx_reg + 8'h01 == len_reg)
						state_next = R_SUM;
				end
				R_SUM:
				begin
					if (sum_after != 8'h00)
						err_next = 1'b1;
					else if (type_reg == loader_pkg::REC_END)
						end_next = 1'b1;
					state_next = R_MARK;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= R_MARK;
			len_reg <= 8'h00;
			type_reg <= 8'h00;
			off_reg <= 16'h0000;
			ext_reg <= 16'h0000;
			sum_reg <= 8'h00;
			idx_reg <= 8'h00;
			pay_reg <= '0;
			end_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			len_reg <= len_next;
			type_reg <= type_next;
			off_reg <= off_next;
			ext_reg <= ext_next;
			sum_reg <= sum_next;
			idx_reg <= idx_next;
			pay_reg <= pay_next;
			end_reg <= end_next;
			err_reg <= err_next;
		end
	end

	assign pay_o = pay_reg;
	assign end_o = end_reg;
	assign err_o = err_reg;

endmodule

`default_nettype wire

// file: core/serial_loader_checksum_password.sv
// checksum, hex record and password engine of the serial programming loader
// assumes received bytes arrive at least three clocks apart and memory reads answer within the cycle that mem_o.rd stands
// Functional notes
// - checksum adds covered data byte by byte, returned as one 16-bit word.
// - flash write and sum modes sum whole flash, both regions, always.
// - record length, address, type and checksum fields never enter the checksum.
// - ram loader mode sums ram from first to last received ram address.
// - product id mode sums only transferred bytes nine through eighteen.
// - flash status mode sums only transferred bytes nine through twelve.
// - erase sums erased sector only, or whole flash after full erase.
// - after a record checksum, every byte except 3AH is dropped.
// - receive or record format error halts silently.
// - unknown record type or failed record checksum is a format error.
// - extended address record with length other than 02H is a format error.
// - data record after extended address 1000H or above is a format error.
// - end record with length other than 00H is a format error.
// - password bytes compared to eight or more flash bytes; mismatch halts.
// - password locations outside the two flash regions are rejected.
// - non-blank needs count of eight or more and start within 04000H..21F00H-count.
// - all FFH at FFFE0H..FFFFFH means blank; comparison skipped, addresses still sent.
// - password with three identical consecutive bytes is an error and halts.
// - any password error halts silently; only reset recovers.
// - blank device expects records right after compare start; stray 3AH starts one.
// - once halted, all link traffic stops until reset.
`timescale 1ns/1ps
`default_nettype none

module serial_loader_checksum_password
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire loader_pkg::mode_type mode_i,
	input wire logic erase_full_i,
	input wire logic [19:0] erase_lo_i,
	input wire logic [19:0] erase_hi_i,
	input wire loader_pkg::byte_type rx_i,
	input wire logic rx_error_i,
	input wire loader_pkg::byte_type out_i,
	output loader_pkg::mem_req_type mem_o,
	input wire logic [7:0] mem_data_i,
	output loader_pkg::write_type wr_o,
	output loader_pkg::byte_type tx_o,
	input wire logic tx_ready_i,
	output logic [15:0] sum_o,
	output logic done_o,
	output logic halt_o
);

	// ----------------------------------------------------------------
	// state and registers
	// ----------------------------------------------------------------
	typedef enum {ST_IDLE, ST_PW_ADDR, ST_BLANK, ST_COUNT, ST_PW_CMP, ST_HEX, ST_SWEEP,
		ST_TX_HI, ST_TX_LO, ST_OUT_SUM, ST_HALT} state_type;

	state_type state_reg, state_next;
	loader_pkg::mode_type mode_reg, mode_next;
	logic [47:0] pw_addr_reg, pw_addr_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] pw_n_reg, pw_n_next;
	logic [7:0] cur_reg, cur_next;
	logic [7:0] prev_reg, prev_next;
	logic [1:0] run_reg, run_next;
	logic rd_wait_reg, rd_wait_next;
	logic blank_reg, blank_next;
	logic seg2_reg, seg2_next;
	logic [19:0] addr_reg, addr_next;
	logic [19:0] end_reg, end_next;
	logic ram_seen_reg, ram_seen_next;
	logic [19:0] ram_first_reg, ram_first_next;
	logic [19:0] ram_last_reg, ram_last_next;
	loader_pkg::mem_req_type mem_reg, mem_next;
	loader_pkg::byte_type tx_reg, tx_next;
	logic done_reg, done_next;
	logic acc_clear;
	logic acc_add;
	logic [7:0] acc_byte;
	logic [15:0] acc_sum;
	loader_pkg::write_type pay;
	logic hex_end;
	logic hex_err;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic [23:0] pw_count_location = pw_addr_reg[47:24];
	wire logic [23:0] pw_compare_start = pw_addr_reg[23:0];
	wire logic [19:0] cnt_loc20 = pw_count_location[19:0];
	wire logic [19:0] cmp_start20 = pw_compare_start[19:0];
	wire logic in_flash_cnt = cnt_loc20 >= loader_pkg::FLASH_LO && cnt_loc20 <= loader_pkg::FLASH_HI;
	wire logic in_top_cnt = cnt_loc20 >= loader_pkg::TOP_LO;
	wire logic cnt_loc_ok = pw_count_location[23:20] == 4'h0 && (in_flash_cnt || in_top_cnt);
	wire logic cmp_start_ok = pw_compare_start[23:20] == 4'h0 && cmp_start20 >= loader_pkg::FLASH_LO
		&& cmp_start20 <= loader_pkg::FLASH_HI;
	wire logic [20:0] cmp_end = {1'b0, cmp_start20} + {13'h0000, mem_data_i};
	wire logic count_ok = mem_data_i >= loader_pkg::PW_MIN_COUNT && cmp_end <= loader_pkg::PW_CMP_LIMIT;
	wire logic needs_pw = mode_reg == loader_pkg::MODE_FLASH_WRITE || mode_reg == loader_pkg::MODE_RAM_LOAD
		|| mode_reg == loader_pkg::MODE_ERASE;
	wire logic hex_mode = mode_reg == loader_pkg::MODE_FLASH_WRITE || mode_reg == loader_pkg::MODE_RAM_LOAD;
	wire logic [7:0] out_idx = cnt_reg + 8'h01;
	wire logic [7:0] win_first = (mode_reg == loader_pkg::MODE_ID_OUT) ? loader_pkg::ID_SUM_FIRST
		: loader_pkg::STATUS_SUM_FIRST;
	wire logic [7:0] win_last = (mode_reg == loader_pkg::MODE_ID_OUT) ? loader_pkg::ID_SUM_LAST
		: loader_pkg::STATUS_SUM_LAST;
	wire logic out_in_win = out_idx >= win_first && out_idx <= win_last;
	wire logic active = state_reg != ST_IDLE && state_reg != ST_HALT;
	wire logic sweep_add = state_reg == ST_SWEEP && rd_wait_reg;
	wire logic out_add = state_reg == ST_OUT_SUM && out_i.valid && out_in_win;
	wire loader_pkg::byte_type hex_rx = '{valid: rx_i.valid && state_reg == ST_HEX, data: rx_i.data};

	assign acc_clear = state_reg == ST_IDLE && start_i;
	assign acc_add = sweep_add || out_add;
	assign acc_byte = sweep_add ? mem_data_i : out_i.data;

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	checksum_acc acc_u
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(acc_clear),
		.add_i(acc_add),
		.byte_i(acc_byte),
		.sum_o(acc_sum)
	);

	hex_record_check hex_u
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(acc_clear),
		.rx_i(hex_rx),
		.pay_o(pay),
		.end_o(hex_end),
		.err_o(hex_err)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		mode_next = mode_reg;
		pw_addr_next = pw_addr_reg;
		cnt_next = cnt_reg;
		pw_n_next = pw_n_reg;
		cur_next = cur_reg;
		prev_next = prev_reg;
		run_next = run_reg;
		rd_wait_next = 1'b0;
		blank_next = blank_reg;
		seg2_next = seg2_reg;
		addr_next = addr_reg;
		end_next = end_reg;
		ram_seen_next = ram_seen_reg;
		ram_first_next = ram_first_reg;
		ram_last_next = ram_last_reg;
		mem_next = '0;
		tx_next = tx_reg;
		done_next = 1'b0;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (start_i)
				begin
					mode_next = mode_i;
					cnt_next = 8'h00;
					ram_seen_next = 1'b0;
					if (mode_i == loader_pkg::MODE_SUM_OUT)
					begin
						addr_next = loader_pkg::FLASH_LO;
						end_next = loader_pkg::FLASH_HI;
						seg2_next = 1'b1;
						state_next = ST_SWEEP;
					end
					else if (mode_i == loader_pkg::MODE_ID_OUT || mode_i == loader_pkg::MODE_STATUS_OUT)
						state_next = ST_OUT_SUM;
					else
						state_next = ST_PW_ADDR;
				end
			end
			ST_PW_ADDR:
			begin
				// both location fields are taken even from a blank device
				if (rx_i.valid)
				begin
					pw_addr_next = {pw_addr_reg[39:0], rx_i.data};
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg == 8'(loader_pkg::PW_ADDR_BYTES - 3'h1))
					begin
						addr_next = loader_pkg::BLANK_LO;
						blank_next = 1'b1;
						state_next = ST_BLANK;
					end
				end
			end
			ST_BLANK:
			begin
				if (!cnt_loc_ok || !cmp_start_ok)
					state_next = ST_HALT;
				else if (!rd_wait_reg)
				begin
					mem_next = '{rd: 1'b1, ram: 1'b0, addr: addr_reg};
					rd_wait_next = 1'b1;
				end
				else
				begin
					blank_next = blank_reg && mem_data_i == loader_pkg::ERASED_BYTE;
					addr_next = addr_reg + 20'h00001;
					if (addr_reg == loader_pkg::TOP_HI)
					begin
						if (blank_reg && mem_data_i == loader_pkg::ERASED_BYTE)
							state_next = hex_mode ? ST_HEX : ST_SWEEP;
						else
							state_next = ST_COUNT;
					end
				end
				if (state_next == ST_SWEEP)
				begin
					addr_next = erase_full_i ? loader_pkg::FLASH_LO : erase_lo_i;
					end_next = erase_full_i ? loader_pkg::FLASH_HI : erase_hi_i;
					seg2_next = erase_full_i;
				end
			end
			ST_COUNT:
			begin
				if (!rd_wait_reg)
				begin
					mem_next = '{rd: 1'b1, ram: 1'b0, addr: cnt_loc20};
					rd_wait_next = 1'b1;
				end
				else if (!count_ok)
					state_next = ST_HALT;
				else
				begin
					pw_n_next = mem_data_i;
					cnt_next = 8'h00;
					run_next = 2'h0;
					state_next = ST_PW_CMP;
				end
			end
			ST_PW_CMP:
			begin
				if (!rd_wait_reg && rx_i.valid)
				begin
					cur_next = rx_i.data;
					mem_next = '{rd: 1'b1, ram: 1'b0, addr: cmp_start20 + {12'h000, cnt_reg}};
					rd_wait_next = 1'b1;
				end
				else if (rd_wait_reg)
				begin
					run_next = (cnt_reg != 8'h00 && cur_reg == prev_reg) ? run_reg + 2'h1 : 2'h0;
					prev_next = cur_reg;
					cnt_next = cnt_reg + 8'h01;
					if (mem_data_i != cur_reg)
						state_next = ST_HALT;
					else if (cnt_reg != 8'h00 && cur_reg == prev_reg && run_reg == loader_pkg::PW_RUN_LIMIT - 2'h1)
						state_next = ST_HALT;
					else if (cnt_reg + 8'h01 == pw_n_reg)
						state_next = hex_mode ? ST_HEX : ST_SWEEP;
				end
				if (state_next == ST_SWEEP)
				begin
					addr_next = erase_full_i ? loader_pkg::FLASH_LO : erase_lo_i;
					end_next = erase_full_i ? loader_pkg::FLASH_HI : erase_hi_i;
					seg2_next = erase_full_i;
				end
			end
			ST_HEX:
			begin
				if (pay.valid)
				begin
					ram_seen_next = 1'b1;
					ram_last_next = pay.addr;
					if (!ram_seen_reg)
						ram_first_next = pay.addr;
				end
				if (hex_err)
					state_next = ST_HALT;
				else if (hex_end)
				begin
					if (mode_reg == loader_pkg::MODE_RAM_LOAD)
					begin
						addr_next = ram_first_reg;
						end_next = ram_last_reg;
						seg2_next = 1'b0;
						state_next = ram_seen_reg ? ST_SWEEP : ST_TX_HI;
					end
					else
					begin
						addr_next = loader_pkg::FLASH_LO;
						end_next = loader_pkg::FLASH_HI;
						seg2_next = 1'b1;
						state_next = ST_SWEEP;
					end
				end
			end
			ST_SWEEP:
			begin
				if (!rd_wait_reg)
				begin
					mem_next = '{rd: 1'b1, ram: mode_reg == loader_pkg::MODE_RAM_LOAD, addr: addr_reg};
					rd_wait_next = 1'b1;
				end
				else if (addr_reg != end_reg)
					addr_next = addr_reg + 20'h00001;
				else if (seg2_reg)
				begin
					addr_next = loader_pkg::TOP_LO;
					end_next = loader_pkg::TOP_HI;
					seg2_next = 1'b0;
				end
				else
					state_next = ST_TX_HI;
			end
			ST_TX_HI:
			begin
				// upper byte first, as the controller expects
				tx_next = '{valid: 1'b1, data: acc_sum[15:8]};
				if (tx_reg.valid && tx_ready_i)
				begin
					tx_next = '{valid: 1'b1, data: acc_sum[7:0]};
					state_next = ST_TX_LO;
				end
			end
			ST_TX_LO:
			begin
				if (tx_ready_i)
				begin
					tx_next = '0;
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			ST_OUT_SUM:
			begin
				if (out_i.valid)
				begin
					cnt_next = out_idx;
					if (out_idx == win_last)
					begin
						done_next = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_HALT:
			begin
				tx_next = '0;
			end
		endcase
		if (active && rx_error_i)
			state_next = ST_HALT;
		if (state_next == ST_HALT)
		begin
			tx_next = '0;
			mem_next = '0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_IDLE;
			mode_reg <= loader_pkg::MODE_FLASH_WRITE;
			pw_addr_reg <= 48'h000000000000;
			cnt_reg <= 8'h00;
			pw_n_reg <= 8'h00;
			cur_reg <= 8'h00;
			prev_reg <= 8'h00;
			run_reg <= 2'h0;
			rd_wait_reg <= 1'b0;
			blank_reg <= 1'b0;
			seg2_reg <= 1'b0;
			addr_reg <= 20'h00000;
			end_reg <= 20'h00000;
			ram_seen_reg <= 1'b0;
			ram_first_reg <= 20'h00000;
			ram_last_reg <= 20'h00000;
			mem_reg <= '0;
			tx_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			pw_addr_reg <= pw_addr_next;
			cnt_reg <= cnt_next;
			pw_n_reg <= pw_n_next;
			cur_reg <= cur_next;
			prev_reg <= prev_next;
			run_reg <= run_next;
			rd_wait_reg <= rd_wait_next;
			blank_reg <= blank_next;
			seg2_reg <= seg2_next;
			addr_reg <= addr_next;
			end_reg <= end_next;
			ram_seen_reg <= ram_seen_next;
			ram_first_reg <= ram_first_next;
			ram_last_reg <= ram_last_next;
			mem_reg <= mem_next;
			tx_reg <= tx_next;
			done_reg <= done_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// record writes stop at once on halt; the parser's last beat is masked
	assign wr_o = (state_reg == ST_HEX) ? pay : '0;
	assign mem_o = mem_reg;
	assign tx_o = tx_reg;
	assign sum_o = acc_sum;
	assign done_o = done_reg;
	assign halt_o = state_reg == ST_HALT;

endmodule

`default_nettype wire

// file: dv/loader_chk.sv
// port checker for the loader checksum and password block
// assumes it is bound to the top module by the bind after the module
`timescale 1ns/1ps
`default_nettype none
module loader_chk
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire loader_pkg::mem_req_type mem_o,
	input wire loader_pkg::write_type wr_o,
	input wire loader_pkg::byte_type tx_o,
	input wire logic tx_ready_i,
	input wire logic done_o,
	input wire logic halt_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_halt_sticky: assert property (halt_o |=> halt_o) else $error("halt released without reset");
	a_halt_silent: assert property (halt_o |-> !tx_o.valid) else $error("byte sent while halted");
	a_halt_nowr: assert property (halt_o |-> !wr_o.valid && !done_o) else $error("activity while halted");
	a_halt_nomem: assert property (halt_o |-> !mem_o.rd) else $error("memory read while halted");
	a_tx_hold: assert property (tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data))
		else $error("checksum byte dropped before acceptance");
	a_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
	a_read_gap: assert property (mem_o.rd |=> !mem_o.rd) else $error("reads back to back");
	a_write_pulse: assert property (wr_o.valid |=> !wr_o.valid) else $error("payload write repeated");
endmodule
bind serial_loader_checksum_password loader_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .mem_o(mem_o), .wr_o(wr_o),
	.tx_o(tx_o), .tx_ready_i(tx_ready_i), .done_o(done_o), .halt_o(halt_o));
`default_nettype wire

// file: dv/flash_partner.sv
// memory seen by the loader: flash and ram contents, answered within the cycle that mem_i.rd stands
// assumes unwritten flash is erased, and FFFE0H..FFFFFH reads 00H when not blank
`timescale 1ns/1ps
`default_nettype none
module flash_partner
(
	input wire logic clk_i,
	input wire logic blank_i,
	input wire loader_pkg::mem_req_type mem_i,
	input wire loader_pkg::write_type wr_i,
	output logic [7:0] data_o
);
	logic [7:0] store [int];
	initial data_o = 8'h00;
	always @(posedge clk_i)
	begin
		if (wr_i.valid)
			store[int'(wr_i.addr)] = wr_i.data;
	end
	// the loader takes the answer at the edge that ends its request cycle, so it is set mid-cycle;
	// outside the answer cycle the bus toggles, so stale data never looks valid
	always @(negedge clk_i)
	begin
		if (mem_i.rd)
			data_o <= store.exists(int'(mem_i.addr)) ? store[int'(mem_i.addr)] :
				((blank_i || mem_i.addr < 20'hFFFE0) ? 8'hFF : 8'h00);
		else
			data_o <= ~data_o;
	end
endmodule
`default_nettype wire

// file: dv/serial_loader_checksum_password_bench.sv
// self-checking bench: output-mode sums, a ram load on a blank part, silent halts
// assumes the checker is bound by its own file and the partner answers memory reads
`timescale 1ns/1ps
`default_nettype none
module serial_loader_checksum_password_bench;
	logic clk_i = 0;
	logic rst_i = 1;
	logic start_i = 0;
	loader_pkg::mode_type mode_i = loader_pkg::MODE_STATUS_OUT;
	logic erase_full_i = 0;
	logic [19:0] erase_lo_i = 20'h04000;
	logic [19:0] erase_hi_i = 20'h0400F;
	logic blank_flag = 1;
	loader_pkg::byte_type rx_i = '0;
	loader_pkg::byte_type out_i = '0;
	logic rx_error_i = 0;
	logic tx_ready_i = 0;
	loader_pkg::mem_req_type mem_o;
	loader_pkg::write_type wr_o;
	loader_pkg::byte_type tx_o;
	logic [7:0] mem_data_i;
	logic [15:0] sum_o;
	logic done_o;
	logic halt_o;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	serial_loader_checksum_password DUT (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i),
		.erase_full_i(erase_full_i), .erase_lo_i(erase_lo_i), .erase_hi_i(erase_hi_i), .rx_i(rx_i),
		.rx_error_i(rx_error_i), .out_i(out_i), .mem_o(mem_o), .mem_data_i(mem_data_i), .wr_o(wr_o),
		.tx_o(tx_o), .tx_ready_i(tx_ready_i), .sum_o(sum_o), .done_o(done_o), .halt_o(halt_o));
	flash_partner mem (.clk_i(clk_i), .blank_i(blank_flag), .mem_i(mem_o), .wr_i(wr_o), .data_o(mem_data_i));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize();
		end
	end
	task summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task reset_dut();
		rst_i = 1;
		repeat (8) @(negedge clk_i);
		rst_i = 0;
	endtask
	task go(input loader_pkg::mode_type m);
		@(negedge clk_i);
		start_i = 1;
		mode_i = m;
		@(negedge clk_i);
		start_i = 0;
	endtask
	task sb(input logic [7:0] b);
		@(negedge clk_i);
		rx_i = {1'b1, b};
		@(negedge clk_i);
		rx_i = '0;
		@(negedge clk_i);
	endtask
	task wait_done(output logic seen);
		seen = done_o === 1'b1;
		for (int i = 0; i < 5 && !seen; i++)
		begin
			@(negedge clk_i);
			seen = done_o === 1'b1;
		end
	endtask
	task get_byte(output logic [7:0] b);
		for (int n = 0; n < 3000 && tx_o.valid !== 1'b1; n++)
			@(negedge clk_i);
		// stall the sink first so the byte must stand
		repeat (2) @(negedge clk_i);
		tx_ready_i = 1;
		b = tx_o.data;
		@(negedge clk_i);
		tx_ready_i = 0;
	endtask
	task rec(input logic [7:0] typ, input logic [7:0] q[$]);
		logic [7:0] c;
		c = 8'(q.size()) + 8'h10 + typ;
		sb(8'h3A);
		sb(8'(q.size()));
		sb(8'h00);
		sb(8'h10);
		sb(typ);
		foreach (q[i])
		begin
			sb(q[i]);
			c += q[i];
		end
		sb(8'h00 - c);
	endtask
	task preamble(input loader_pkg::mode_type m);
		logic [7:0] a[6];
		// one fixed pair of password locations for every run
		a = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h40, 8'h08};
		go(m);
		foreach (a[i])
			sb(a[i]);
		repeat (80) @(negedge clk_i);
	endtask
	task out_test(input loader_pkg::mode_type m, input int last);
		int s;
		logic [7:0] b;
		logic seen;
		s = 0;
		go(m);
		for (int i = 1; i <= last; i++)
		begin
			b = 8'($urandom);
			@(negedge clk_i);
			out_i = {1'b1, b};
			if (i >= 9)
				s += b;
		end
		@(negedge clk_i);
		out_i = '0;
		wait_done(seen);
		chk(16'(seen), 16'h0001);
		chk(sum_o, s[15:0]);
		$display("output mode sum test over %0d bytes done", last);
	endtask
	task ram_test();
		logic [7:0] q[$];
		logic [7:0] hi;
		logic [7:0] lo;
		logic seen;
		int s;
		s = 0;
		preamble(loader_pkg::MODE_RAM_LOAD);
		sb(8'h55);
		for (int i = 0; i < 4; i++)
		begin
			q.push_back(8'($urandom));
			s += q[i];
		end
		rec(8'h00, q);
		sb(8'h5A);
		q = {};
		rec(8'h01, q);
		get_byte(hi);
		get_byte(lo);
		chk({hi, lo}, s[15:0]);
		wait_done(seen);
		chk(16'(seen), 16'h0001);
		$display("ram load test done");
	endtask
	task erase_test();
		logic [7:0] hi;
		logic [7:0] lo;
		logic seen;
		// blank part in erase mode: only the two location fields, no password string
		preamble(loader_pkg::MODE_ERASE);
		get_byte(hi);
		get_byte(lo);
		// sixteen erased bytes of FFH in the sector 04000H..0400FH
		chk({hi, lo}, 16'h0FF0);
		wait_done(seen);
		chk(16'(seen), 16'h0001);
		$display("erase sector test done");
	endtask
	task halt_test(input int k);
		logic [7:0] q[$];
		blank_flag = k < 2;
		reset_dut();
		preamble(loader_pkg::MODE_RAM_LOAD);
		if (k == 1)
		begin
			@(negedge clk_i);
			rx_error_i = 1;
			@(negedge clk_i);
			rx_error_i = 0;
		end
		else if (k == 0)
			rec(8'h05, q);
		else if (k == 2)
			repeat (3) sb(8'hFF);
		else
			sb(8'h00);
		repeat (4) @(negedge clk_i);
		chk(16'(halt_o), 16'h0001);
		go(loader_pkg::MODE_STATUS_OUT);
		repeat (20) @(negedge clk_i);
		chk(16'(halt_o), 16'h0001);
		$display("halt test %0d done", k);
	endtask
	initial
	begin
		void'($urandom(32'h3ace));
		reset_dut();
		out_test(loader_pkg::MODE_STATUS_OUT, 12);
		out_test(loader_pkg::MODE_ID_OUT, 18);
		ram_test();
		erase_test();
		halt_test(0);
		halt_test(1);
		halt_test(2);
		halt_test(3);
		summarize();
	end
endmodule
`default_nettype wire
